// ===== hw/rsr_reference_setpoint_regs.v
// Scratch, trim and margin-up registers and the reference code
//
// Function
// - Scratch word: only low eight bits writable; high byte reads zero.
// - Scratch word uses word transfers only; a byte read is refused.
// - Store-all copies scratch and trim to nonvolatile; both reset zero.
// - Loop follower discards writes to trim and margin-up unchanged.
// - Follower access to trim or margin-up: no ack, fault, alert.
// - Reference equals command times loop scale plus trim, 1.953 mV LSB.
// - Margin-up added while operation bit 5; margin-down while bit 4.
// - Trim and margin use linear format, fixed exponent minus nine.
// - Trim limited to -64 through +63 LSB in single steps.
// - Out-of-range write clamps to limit, alerts, sets comm and data.
// - Combined reference also bounded by maximum and minimum limits.
// - Reference ramps at rise, transition or fall rate by state.
// - Trim is 16-bit two's complement, read/write, sign extended.
// - Margin-up accepts 0 to 31 in low five bits; rest read zero.
// - Margin-up restores to 0009h or 000fh by the option bit.
`timescale 1ns/100ps
`include "rsr_setpoint_regs.vh"
module rsr_reference_setpoint_regs (
    input wire ref_clk,
    input wire rst_n,
    input wire req_valid,
    input wire [7:0] req_code,
    input wire req_write,
    input wire req_word,
    input wire [15:0] req_wdata,
    input wire txn_end,
    input wire txn_abort,
    output reg rsp_valid,
    output reg rsp_ack,
    output reg [15:0] rsp_rdata,
    input wire loop_follower_pin,
    input wire [7:0] operation,
    input wire [15:0] vout_command,
    input wire [7:0] vout_scale_loop,
    input wire [15:0] vout_max,
    input wire [15:0] vout_min,
    input wire [15:0] margin_down_step,
    input wire [1:0] ramp_state,
    input wire [15:0] rise_period,
    input wire [15:0] transition_period,
    input wire [15:0] fall_period,
    input wire store_all,
    input wire restore_all,
    input wire [15:0] nv_scratch_in,
    input wire [15:0] nv_trim_in,
    input wire margin_up_restore_select,
    input wire clear_faults,
    output reg nv_store_valid,
    output reg [15:0] nv_scratch_out,
    output reg [15:0] nv_trim_out,
    output reg invalid_command_fault,
    output reg comm_fault,
    output reg invalid_data,
    output reg alert,
    output wire [15:0] error_amp_reference
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    reg [15:0] user_scratch_word;
    reg [15:0] reference_trim_offset;
    reg [15:0] margin_up_step;
    reg loaded;
    reg follower_meta;
    reg follower;
    reg pend_valid;
    reg [7:0] pend_code;
    reg [15:0] pend_data;
    reg pend_bad;
    reg [15:0] target;
    reg [15:0] period;

    wire hit_scratch;
    wire hit_trim;
    wire hit_mup;
    wire hit_any;
    wire guarded;
    wire refuse;
    wire set_ivc;
    wire set_cml;
    wire commit;

    reg [15:0] clamped;
    reg out_of_range;
    reg [15:0] next_target;
    reg [15:0] next_period;
    reg [15:0] rd_value;

    wire [23:0] product;
    wire [19:0] scaled;
    wire [19:0] trim_ext;
    wire [19:0] mup_ext;
    wire [19:0] mdn_ext;
    wire [19:0] sum;

    // ----------------------------------------------------------------
    // Follower strap synchroniser
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            follower_meta <= 1'b0;
            follower <= 1'b0;
        end else begin
            follower_meta <= loop_follower_pin;
            follower <= follower_meta;
        end
    end

    // ----------------------------------------------------------------
    // Request decode
    // ----------------------------------------------------------------
    assign hit_scratch = (req_code == `RSR_CODE_SCRATCH);
    assign hit_trim = (req_code == `RSR_CODE_TRIM);
    assign hit_mup = (req_code == `RSR_CODE_MARGIN_UP);
    assign hit_any = hit_scratch | hit_trim | hit_mup;
    assign guarded = (hit_trim | hit_mup) & follower;
    // Scratch is a word command; a byte access of it is not legal
    assign refuse = guarded | (hit_scratch & ~req_word);
    assign set_ivc = req_valid & hit_any & refuse;
    assign commit = pend_valid & txn_end;
    assign set_cml = commit & pend_bad;

    // ----------------------------------------------------------------
    // Write data clamping
    // ----------------------------------------------------------------
    always @* begin
        clamped = req_wdata;
        out_of_range = 1'b0;
        if (hit_trim) begin
            // Signed compare covers a high byte that is not a sign copy
            if ($signed(req_wdata) > $signed(`RSR_TRIM_MAX)) begin
                clamped = `RSR_TRIM_MAX;
                out_of_range = 1'b1;
            end else if ($signed(req_wdata) < $signed(`RSR_TRIM_MIN)) begin
                clamped = `RSR_TRIM_MIN;
                out_of_range = 1'b1;
            end
        end else if (hit_mup) begin
            if ($signed(req_wdata) > $signed(`RSR_MARGIN_UP_MAX)) begin
                clamped = `RSR_MARGIN_UP_MAX;
                out_of_range = 1'b1;
            end else if ($signed(req_wdata) <
                $signed(`RSR_MARGIN_UP_MIN)) begin
                clamped = `RSR_MARGIN_UP_MIN;
                out_of_range = 1'b1;
            end
        end else begin
            clamped = req_wdata & `RSR_SCRATCH_WR_MASK;
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always @* begin
        rd_value = 16'h0000;
        if (hit_scratch) begin
            rd_value = user_scratch_word & `RSR_SCRATCH_WR_MASK;
        end else if (hit_trim) begin
            rd_value = reference_trim_offset;
        end else if (hit_mup) begin
            rd_value = margin_up_step & `RSR_MARGIN_UP_MAX;
        end
    end

    // ----------------------------------------------------------------
    // Response and pending write
    // ----------------------------------------------------------------
    // Writes are held until the host closes the transaction, so a
    // write cut short never reaches the reference.
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_ack <= 1'b0;
            rsp_rdata <= 16'h0000;
            pend_valid <= 1'b0;
            pend_code <= 8'h00;
            pend_data <= 16'h0000;
            pend_bad <= 1'b0;
        end else begin
            rsp_valid <= req_valid & hit_any;
            rsp_ack <= req_valid & hit_any & ~refuse;
            if (req_valid & hit_any & ~refuse & ~req_write) begin
                rsp_rdata <= rd_value;
            end else begin
                rsp_rdata <= 16'h0000;
            end
            if (req_valid & hit_any & ~refuse & req_write) begin
                pend_valid <= 1'b1;
                pend_code <= req_code;
                pend_data <= clamped;
                pend_bad <= out_of_range;
            end else if (txn_end | txn_abort) begin
                pend_valid <= 1'b0;
                pend_bad <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Register storage, restore and commit
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            loaded <= 1'b0;
            user_scratch_word <= `RSR_SCRATCH_RESET;
            reference_trim_offset <= `RSR_TRIM_RESET;
            margin_up_step <= `RSR_MARGIN_UP_RESTORE_LO;
        end else if (!loaded | restore_all) begin
            // Nonvolatile copies are taken one clock after release
            loaded <= 1'b1;
            user_scratch_word <= nv_scratch_in & `RSR_SCRATCH_WR_MASK;
            reference_trim_offset <= nv_trim_in;
            if (margin_up_restore_select) begin
                margin_up_step <= `RSR_MARGIN_UP_RESTORE_HI;
            end else begin
                margin_up_step <= `RSR_MARGIN_UP_RESTORE_LO;
            end
        end else if (commit) begin
            case (pend_code)
                `RSR_CODE_SCRATCH: begin
                    user_scratch_word <= pend_data;
                end
                `RSR_CODE_TRIM: begin
                    if (!follower) begin
                        reference_trim_offset <= pend_data;
                    end
                end
                `RSR_CODE_MARGIN_UP: begin
                    if (!follower) begin
                        margin_up_step <= pend_data;
                    end
                end
                default: begin
                    user_scratch_word <= user_scratch_word;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Nonvolatile store request
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            nv_store_valid <= 1'b0;
            nv_scratch_out <= 16'h0000;
            nv_trim_out <= 16'h0000;
        end else begin
            nv_store_valid <= store_all;
            if (store_all) begin
                nv_scratch_out <= user_scratch_word;
                nv_trim_out <= reference_trim_offset;
            end
        end
    end

    // ----------------------------------------------------------------
    // Fault flags; a new event beats a clear in the same cycle
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            invalid_command_fault <= 1'b0;
            comm_fault <= 1'b0;
            invalid_data <= 1'b0;
            alert <= 1'b0;
        end else begin
            if (set_ivc) begin
                invalid_command_fault <= 1'b1;
            end else if (clear_faults) begin
                invalid_command_fault <= 1'b0;
            end
            if (set_ivc | set_cml) begin
                comm_fault <= 1'b1;
            end else if (clear_faults) begin
                comm_fault <= 1'b0;
            end
            if (set_cml) begin
                invalid_data <= 1'b1;
            end else if (clear_faults) begin
                invalid_data <= 1'b0;
            end
            if (set_ivc | set_cml) begin
                alert <= 1'b1;
            end else if (clear_faults) begin
                alert <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Reference target
    // ----------------------------------------------------------------
    // All terms are reference LSBs (exponent fixed at minus nine), so
    // they add without shifting; the loop scale is a fixed-point
    // fraction with a fixed binary point.
    assign product = vout_command * vout_scale_loop;
    assign scaled = {3'b000, product[23:`RSR_SCALE_FRAC_BITS]};
    assign trim_ext = {{4{reference_trim_offset[15]}}, reference_trim_offset};
    assign mup_ext = operation[`RSR_OP_MARGIN_UP_BIT] ?
        {4'h0, margin_up_step} : 20'h00000;
    assign mdn_ext = operation[`RSR_OP_MARGIN_DOWN_BIT] ?
        {{4{margin_down_step[15]}}, margin_down_step} : 20'h00000;
    assign sum = scaled + trim_ext + mup_ext + mdn_ext;

    always @* begin
        next_target = sum[15:0];
        // The minimum check also catches a negative sum
        if ($signed(sum) < $signed({4'h0, vout_min})) begin
            next_target = vout_min;
        end else if ($signed(sum) > $signed({4'h0, vout_max})) begin
            next_target = vout_max;
        end
    end

    always @* begin
        case (ramp_state)
            `RSR_STATE_SOFT_START: begin
                next_period = rise_period;
            end
            `RSR_STATE_STEADY: begin
                next_period = transition_period;
            end
            `RSR_STATE_TOFF_DELAY: begin
                next_period = transition_period;
            end
            `RSR_STATE_SOFT_STOP: begin
                next_period = fall_period;
            end
            default: begin
                next_period = transition_period;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            target <= 16'h0000;
            period <= 16'h0000;
        end else begin
            // Registers only move on commit or restore, so the target follows a
            // finished write and never a half-written one
            target <= next_target;
            period <= next_period;
        end
    end

    // ----------------------------------------------------------------
    // Slew limiter
    // ----------------------------------------------------------------
    rsr_ramp u_ramp (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .target(target),
        .period(period),
        .level(error_amp_reference)
    );

endmodule

// ===== include/rsr_setpoint_regs.vh
// Constants for the reference setpoint register bank
`ifndef RSR_SETPOINT_REGS_VH
`define RSR_SETPOINT_REGS_VH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define RSR_CODE_SCRATCH 8'hd0
`define RSR_CODE_TRIM 8'hd4
`define RSR_CODE_MARGIN_UP 8'hd5

// ----------------------------------------------------------------
// Reset and restore values
// ----------------------------------------------------------------
`define RSR_SCRATCH_RESET 16'h0000
`define RSR_TRIM_RESET 16'h0000
`define RSR_MARGIN_UP_RESTORE_LO 16'h0009
`define RSR_MARGIN_UP_RESTORE_HI 16'h000f

// ----------------------------------------------------------------
// Field layout and legal ranges
// ----------------------------------------------------------------
`define RSR_SCRATCH_WR_MASK 16'h00ff
`define RSR_TRIM_MAX 16'h003f
`define RSR_TRIM_MIN 16'hffc0
`define RSR_MARGIN_UP_MAX 16'h001f
`define RSR_MARGIN_UP_MIN 16'h0000
`define RSR_OP_MARGIN_UP_BIT 5
`define RSR_OP_MARGIN_DOWN_BIT 4
`define RSR_VOUT_EXPONENT (-9)
`define RSR_REF_LSB_UV 1953
`define RSR_SCALE_FRAC_BITS 7

// ----------------------------------------------------------------
// Converter states that select the ramp rate
// ----------------------------------------------------------------
`define RSR_STATE_SOFT_START 2'h0
`define RSR_STATE_STEADY 2'h1
`define RSR_STATE_TOFF_DELAY 2'h2
`define RSR_STATE_SOFT_STOP 2'h3

`endif

// ===== hw/rsr_ramp.v
// Reference slew stepper: walks the reference toward its target
`timescale 1ns/100ps
module rsr_ramp (
    input wire ref_clk,
    input wire rst_n,
    input wire [15:0] target,
    input wire [15:0] period,
    output reg [15:0] level
);

    reg [15:0] cnt;

    // ----------------------------------------------------------------
    // One LSB per period+1 cycles; a period of zero steps every cycle
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            level <= 16'h0000;
            cnt <= 16'h0000;
        end else if (level == target) begin
            cnt <= 16'h0000;
        end else if (cnt >= period) begin
            cnt <= 16'h0000;
            if (level < target) begin
                level <= level + 16'h0001;
            end else begin
                level <= level - 16'h0001;
            end
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end

endmodule

// ===== tb/rsr_setpoint_properties.sv
// Concurrent checks on the ports of the reference setpoint register bank
`timescale 1ns/100ps
`include "rsr_setpoint_regs.vh"
module rsr_setpoint_properties (
    input wire ref_clk,
    input wire rst_n,
    input wire req_valid,
    input wire [7:0] req_code,
    input wire req_write,
    input wire req_word,
    input wire store_all,
    input wire clear_faults,
    input wire rsp_valid,
    input wire rsp_ack,
    input wire [15:0] rsp_rdata,
    input wire nv_store_valid,
    input wire [15:0] nv_scratch_out,
    input wire invalid_command_fault,
    input wire invalid_data,
    input wire alert,
    input wire [15:0] error_amp_reference
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire known = req_code == `RSR_CODE_SCRATCH || req_code == `RSR_CODE_TRIM
        || req_code == `RSR_CODE_MARGIN_UP;
    sequence byte_req;
        req_valid && req_code == `RSR_CODE_SCRATCH && !req_word;
    endsequence
    sequence refused;
        rsp_valid && !rsp_ack && invalid_command_fault && alert;
    endsequence
    sequence read_ok(c);
        rsp_valid && rsp_ack && $past(req_code) == c && !$past(req_write);
    endsequence
    rsp_timing_a: assert property (
        rsp_valid == $past(req_valid && known))
        else $error("answer not one cycle after request");
    byte_nack_a: assert property (byte_req |=> refused)
        else $error("byte access to scratch word not refused");
    nack_data_a: assert property (
        rsp_valid && !rsp_ack |-> rsp_rdata == 0)
        else $error("refused access returned data");
    scratch_high_a: assert property (read_ok(`RSR_CODE_SCRATCH)
        |-> rsp_rdata[15:8] == 8'h00)
        else $error("scratch high byte not zero");
    margin_range_a: assert property (read_ok(`RSR_CODE_MARGIN_UP)
        |-> rsp_rdata <= `RSR_MARGIN_UP_MAX)
        else $error("margin out of range");
    trim_range_a: assert property (read_ok(`RSR_CODE_TRIM)
        |-> $signed(rsp_rdata) >= -64 && $signed(rsp_rdata) <= 63)
        else $error("trim out of range");
    store_copy_a: assert property (store_all |=> nv_store_valid
        && nv_scratch_out[15:8] == 8'h00) else $error("store copy wrong");
    alert_sticky_a: assert property (
        alert && !clear_faults |=> alert)
        else $error("alert dropped without clear");
    data_alert_a: assert property ($rose(invalid_data) |-> alert)
        else $error("invalid data without alert");
    ref_step_a: assert property ($changed(error_amp_reference) |->
        error_amp_reference - $past(error_amp_reference) == 16'h0001 ||
        $past(error_amp_reference) - error_amp_reference == 16'h0001)
        else $error("reference jumped more than one step");
endmodule

// ===== tb/rsr_host_model.sv
// Host model issuing decoded command phases to the register bank
`timescale 1ns/100ps
module rsr_host_model (
    input logic ref_clk,
    output logic req_valid = 1'b0,
    output logic [7:0] req_code = 8'h00,
    output logic req_write = 1'b0,
    output logic req_word = 1'b1,
    output logic [15:0] req_wdata = 16'h0000,
    output logic txn_end = 1'b0,
    output logic txn_abort = 1'b0,
    input logic rsp_valid,
    input logic rsp_ack,
    input logic [15:0] rsp_rdata
);
    task automatic xfer(input logic [7:0] code, input logic wr, word,
        input logic [15:0] wdata, input logic fin,
        output logic [1:0] resp, output logic [15:0] rdata);
        @(posedge ref_clk);
        #1;
        req_valid = 1'b1;
        req_code = code;
        req_write = wr;
        req_word = word;
        req_wdata = wdata;
        @(posedge ref_clk);
        #1;
        req_valid = 1'b0;
        // Released lines flip so a stale value is never mistaken for data
        req_code = ~code;
        req_wdata = ~wdata;
        resp = {rsp_valid, rsp_ack};
        rdata = rsp_rdata;
        if (wr && fin) begin
            // A refused write is broken off, never finished with a stop
            if (rsp_ack === 1'b1) txn_end = 1'b1;
            else txn_abort = 1'b1;
            @(posedge ref_clk);
            #1;
            txn_end = 1'b0;
            txn_abort = 1'b0;
        end
    endtask
    // Breaks off an open transaction so a pending write is dropped
    task automatic cut;
        txn_abort = 1'b1;
        @(posedge ref_clk);
        #1;
        txn_abort = 1'b0;
    endtask
endmodule

// ===== tb/tb_reference_setpoint_regs.sv
// Self-checking bench for the reference setpoint register bank
`timescale 1ns/100ps
`include "rsr_setpoint_regs.vh"
module tb_reference_setpoint_regs;
    logic ref_clk = 1'b0, rst_n = 1'b0;
    logic req_valid, req_write, req_word, txn_end, txn_abort;
    logic [7:0] req_code;
    logic [15:0] req_wdata, rsp_rdata, nv_scratch_out, nv_trim_out;
    logic rsp_valid, rsp_ack, nv_store_valid, comm_fault, invalid_data, alert;
    logic invalid_command_fault;
    logic [15:0] error_amp_reference;
    logic loop_follower_pin = 1'b0, store_all = 1'b0, restore_all = 1'b0;
    logic clear_faults = 1'b0, margin_up_restore_select = 1'b1;
    logic [7:0] operation = 8'h00, vout_scale_loop = 8'h80;
    logic [15:0] vout_command = 16'h0064, vout_max = 16'h0190;
    logic [15:0] vout_min = 16'h000a, margin_down_step = 16'hfffb;
    logic [1:0] ramp_state = 2'h1;
    logic [15:0] rise_period = 16'h0003, transition_period = 16'h0000;
    logic [15:0] fall_period = 16'h0005;
    logic [15:0] nv_scratch_in = 16'h12a5, nv_trim_in = 16'h0005, rd;
    logic [1:0] resp;
    int fail_count = 0, check_count = 0;

    always #10 ref_clk = ~ref_clk;
    rsr_reference_setpoint_regs DUT (.*);
    rsr_host_model host (.*);

    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        if (fail_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    function automatic logic [15:0] flags();
        return {12'h0, invalid_command_fault, comm_fault, invalid_data, alert};
    endfunction
    task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
        host.xfer(c, 1'b0, 1'b1, 16'h0000, 1'b0, resp, rd);
        check({14'h0, resp}, 16'h0003);
        check(rd, e);
    endtask
    task automatic wr_clamp(input logic [7:0] c, input logic [15:0] w, e,
        input logic f);
        pulse(clear_faults);
        host.xfer(c, 1'b1, 1'b1, w, 1'b1, resp, rd);
        check({14'h0, resp}, 16'h0003);
        rd_chk(c, e);
        check(flags(), f ? 16'h0007 : 16'h0000);
    endtask
    task automatic wait_ref(input logic [15:0] e);
        int n;
        n = 0;
        while (error_amp_reference !== e && n < 600) begin
            tick(1);
            n++;
        end
        check(error_amp_reference, e);
    endtask
    task automatic rate_chk(input int per);
        logic [15:0] v;
        int n;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            v = error_amp_reference;
            while (error_amp_reference === v && n < 50) begin
                tick(1);
                n++;
            end
        end
        check(16'(n), 16'(per + 1));
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_restore;
        rd_chk(`RSR_CODE_SCRATCH, 16'h00a5);
        rd_chk(`RSR_CODE_TRIM, 16'h0005);
        rd_chk(`RSR_CODE_MARGIN_UP, `RSR_MARGIN_UP_RESTORE_HI);
        margin_up_restore_select = 1'b0;
        pulse(restore_all);
        rd_chk(`RSR_CODE_MARGIN_UP, `RSR_MARGIN_UP_RESTORE_LO);
    endtask
    task automatic t_scratch;
        wr_clamp(`RSR_CODE_SCRATCH, 16'hbeef, 16'h00ef, 1'b0);
        host.xfer(`RSR_CODE_SCRATCH, 1'b0, 1'b0, 16'h0000, 1'b0, resp, rd);
        check({14'h0, resp}, 16'h0002);
        check(flags(), 16'h000d);
        host.xfer(`RSR_CODE_SCRATCH, 1'b1, 1'b0, 16'h0011, 1'b1, resp, rd);
        check({14'h0, resp}, 16'h0002);
        rd_chk(`RSR_CODE_SCRATCH, 16'h00ef);
        pulse(clear_faults);
        check(flags(), 16'h0000);
        host.xfer(8'hd1, 1'b0, 1'b1, 16'h0000, 1'b0, resp, rd);
        check({14'h0, resp}, 16'h0000);
    endtask
    task automatic t_clamp;
        wr_clamp(`RSR_CODE_TRIM, 16'h0050, 16'h003f, 1'b1);
        wr_clamp(`RSR_CODE_TRIM, 16'hff00, 16'hffc0, 1'b1);
        wr_clamp(`RSR_CODE_TRIM, 16'hffc0, 16'hffc0, 1'b0);
        wr_clamp(`RSR_CODE_TRIM, 16'h003f, 16'h003f, 1'b0);
        wr_clamp(`RSR_CODE_MARGIN_UP, 16'h0020, 16'h001f, 1'b1);
        wr_clamp(`RSR_CODE_MARGIN_UP, 16'h8000, 16'h0000, 1'b1);
        wr_clamp(`RSR_CODE_MARGIN_UP, 16'h0007, 16'h0007, 1'b0);
    endtask
    task automatic t_reference;
        wr_clamp(`RSR_CODE_TRIM, 16'h0003, 16'h0003, 1'b0);
        wait_ref(16'd103);
        operation = 8'h20;
        wait_ref(16'd110);
        operation = 8'h30;
        wait_ref(16'd105);
        operation = 8'h10;
        wait_ref(16'd98);
        operation = 8'h20;
        vout_max = 16'd106;
        wait_ref(16'd106);
        operation = 8'h00;
        vout_max = 16'h0190;
        vout_min = 16'd120;
        wait_ref(16'd120);
        vout_min = 16'h000a;
        vout_scale_loop = 8'hc0;
        wait_ref(16'd153);
        host.xfer(`RSR_CODE_TRIM, 1'b1, 1'b1, 16'h0010, 1'b0, resp, rd);
        tick(20);
        check(error_amp_reference, 16'd153);
        host.cut;
        tick(20);
        check(error_amp_reference, 16'd153);
        wr_clamp(`RSR_CODE_TRIM, 16'h0010, 16'h0010, 1'b0);
        wait_ref(16'd166);
    endtask
    task automatic t_rates;
        transition_period = 16'h0002;
        for (int s = 0; s < 4; s++) begin
            ramp_state = 2'(s);
            operation = operation ^ 8'h20;
            rate_chk(s == 0 ? 3 : (s == 3 ? 5 : 2));
            wait_ref(operation[5] ? 16'd173 : 16'd166);
        end
    endtask
    task automatic t_store_follow;
        pulse(store_all);
        check(16'(nv_store_valid), 16'h0001);
        check(nv_scratch_out, 16'h00ef);
        check(nv_trim_out, 16'h0010);
        loop_follower_pin = 1'b1;
        pulse(clear_faults);
        tick(4);
        host.xfer(`RSR_CODE_TRIM, 1'b1, 1'b1, 16'h0020, 1'b1, resp, rd);
        check({14'h0, resp}, 16'h0002);
        check(flags(), 16'h000d);
        host.xfer(`RSR_CODE_MARGIN_UP, 1'b0, 1'b1, 16'h0000, 1'b0, resp, rd);
        check({14'h0, resp}, 16'h0002);
        rd_chk(`RSR_CODE_SCRATCH, 16'h00ef);
        loop_follower_pin = 1'b0;
        tick(4);
        rd_chk(`RSR_CODE_TRIM, 16'h0010);
        rd_chk(`RSR_CODE_MARGIN_UP, 16'h0007);
    endtask

    initial begin
        tick(8);
        rst_n = 1'b1;
        tick(3);
        t_restore;
        t_scratch;
        t_clamp;
        t_reference;
        t_rates;
        t_store_follow;
        conclude;
    end
    // Whole sequence needs well under a thousand cycles; allow generous margin
    initial begin
        #400000;
        fail_count++;
        conclude;
    end
endmodule
bind rsr_reference_setpoint_regs rsr_setpoint_properties u_props (.ref_clk,
    .rst_n, .req_valid, .req_code, .req_write, .req_word, .store_all,
    .clear_faults, .rsp_valid, .rsp_ack, .rsp_rdata, .nv_store_valid,
    .nv_scratch_out, .invalid_command_fault, .invalid_data, .alert,
    .error_amp_reference);
